/* File: pkg/pin_mux_pkg.sv */
// Constants and carrier types for the upper port pin multiplexer
package pin_mux_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] port_pins_a_off = 8'h00;
  localparam logic [7:0] output_latch_a_off = 8'h04;
  localparam logic [7:0] direction_a_off = 8'h08;
  localparam logic [7:0] analog_select_a_off = 8'h0c;
  localparam logic [7:0] slew_rate_control_off = 8'h10;
  localparam logic [7:0] osc_config_off = 8'h14;

  // ==========================================================
  // Field positions and widths
  localparam int ans_bit5_pos = 5;
  localparam int osc_mode_pos = 0;
  localparam int clkout_en_pos = 2;
  localparam int slew_width = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:4] latch_reset = 4'h0;
  localparam logic [7:4] direction_reset = 4'hf;
  localparam logic analog5_reset = 1'b1;
  localparam logic [4:0] slew_reset = 5'h1f;
  localparam logic [1:0] osc_mode_reset = 2'h0;
  localparam logic clkout_reset = 1'b0;

  // ==========================================================
  // Oscillator modes
  localparam logic [1:0] osc_internal = 2'h0;
  localparam logic [1:0] osc_rc = 2'h1;
  localparam logic [1:0] osc_crystal = 2'h2;
  localparam logic [1:0] osc_ext_clock = 2'h3;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Peripheral output requests toward pins 4 and 5
  typedef struct packed {
    logic sr_q_en;
    logic sr_latch_true_out;
    logic c1_en;
    logic comparator1_output;
    logic cmp_pwm5_en;
    logic compare_pwm_unit5_out;
    logic sr_nq_en;
    logic sr_latch_inverted_out;
    logic c2_en;
    logic comparator2_output;
  } periph_req_s;

endpackage : pin_mux_pkg

/* File: verilog/port_a_upper_pin_mux.sv */
// Output priority and input routing for port pins 4 to 7, AXI4-Lite regs
//
// How it works
// - After reset pin 4 direction bit is 1, pin 4 undriven.
// - Pin 4 output with compare/PWM 5 enabled drives that instead of latch.
// - SR latch true output overrides every other pin 4 source.
// - Pin 4 ranks SR true, comparator 1, compare/PWM 5, then latch.
// - Pin 4 as input feeds the timer 0 external clock.
// - Pin 5 output comes from its latch even when analog-selected.
// - Pin 5 reads zero while analog-selected.
// - Pin 5 input, digital, feeds the SPI client select.
// - Pin 6 is a port pin only in internal mode without clock output.
// - RC mode with clock output drives quarter-rate clock on pin 6.
// - External oscillator modes cut pin 7 output and input.
// - Oscillator-claimed pins 6, 7 read zero in port, direction, latch.
// - Port read shows pins; port write updates the latch.
// - Unimplemented register bits read zero, writes ignored.
// - External clock input always comes from the pin 7 input.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module port_a_upper_pin_mux (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Peripheral requests
  input wire pin_mux_pkg::periph_req_s periph_req,
  // Pins 4 to 7
  input wire logic [7:4] pin_in,
  output logic [7:4] pin_out,
  output logic [7:4] pin_oe_n,
  // Routed inputs
  output logic timer0_ext_clock_in,
  output logic spi_client_select_in,
  output logic external_clock_in
);

  // ==========================================================
  // Register state
  logic [7:4] latch_reg;
  logic [7:4] dir_reg;
  logic ans5_reg;
  logic [4:0] slew_reg;
  logic [1:0] osc_mode_reg;
  logic clkout_en_reg;
  logic [1:0] clk_div_reg;

  // Digital use of pins 6 and 7 left by the oscillator
  function automatic logic [7:6] port_usable(input logic [1:0] mode,
                                            input logic clk_out_on);
    port_usable[6] = (mode == pin_mux_pkg::osc_internal) && !clk_out_on;
    port_usable[7] = (mode == pin_mux_pkg::osc_internal);
  endfunction : port_usable

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == pin_mux_pkg::port_pins_a_off) ||
             (addr == pin_mux_pkg::output_latch_a_off) ||
             (addr == pin_mux_pkg::direction_a_off) ||
             (addr == pin_mux_pkg::analog_select_a_off) ||
             (addr == pin_mux_pkg::slew_rate_control_off) ||
             (addr == pin_mux_pkg::osc_config_off);
  endfunction : mapped

  logic [7:6] usable;
  logic clk_drive;
  assign usable = port_usable(osc_mode_reg, clkout_en_reg);
  // Crystal modes need pin 6 for the oscillator, no clock output there
  assign clk_drive = clkout_en_reg &&
                     (osc_mode_reg == pin_mux_pkg::osc_rc ||
                      osc_mode_reg == pin_mux_pkg::osc_internal);

  // ==========================================================
  // Write channel
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic do_write;
  assign do_write = aw_full && w_full && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      awready <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      awready <= 1'b0;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      wready <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      wready <= 1'b0;
      w_data_reg <= wdata[7:0];
      w_lane0_reg <= wstrb[0];
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= pin_mux_pkg::resp_okay;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr_reg) ? pin_mux_pkg::resp_okay
                                   : pin_mux_pkg::resp_slverr;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register bits; upper lanes are ignored
  logic wr_en;
  assign wr_en = do_write && w_lane0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= pin_mux_pkg::latch_reset;
    end else if (wr_en && (aw_addr_reg == pin_mux_pkg::port_pins_a_off ||
                 aw_addr_reg == pin_mux_pkg::output_latch_a_off)) begin
      latch_reg <= w_data_reg[7:4];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg <= pin_mux_pkg::direction_reset;
    end else if (wr_en && aw_addr_reg == pin_mux_pkg::direction_a_off) begin
      dir_reg <= w_data_reg[7:4];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ans5_reg <= pin_mux_pkg::analog5_reset;
      slew_reg <= pin_mux_pkg::slew_reset;
      osc_mode_reg <= pin_mux_pkg::osc_mode_reset;
      clkout_en_reg <= pin_mux_pkg::clkout_reset;
    end else if (wr_en) begin
      if (aw_addr_reg == pin_mux_pkg::analog_select_a_off) begin
        ans5_reg <= w_data_reg[pin_mux_pkg::ans_bit5_pos];
      end
      if (aw_addr_reg == pin_mux_pkg::slew_rate_control_off) begin
        slew_reg <= w_data_reg[pin_mux_pkg::slew_width-1:0];
      end
      if (aw_addr_reg == pin_mux_pkg::osc_config_off) begin
        osc_mode_reg <= w_data_reg[pin_mux_pkg::osc_mode_pos +: 2];
        clkout_en_reg <= w_data_reg[pin_mux_pkg::clkout_en_pos];
      end
    end
  end

  // ==========================================================
  // Read channel
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (araddr)
      pin_mux_pkg::port_pins_a_off: begin
        rd_byte[4] = pin_in[4];
        rd_byte[5] = pin_in[5] && !ans5_reg;
        rd_byte[7:6] = pin_in[7:6] & usable;
      end
      pin_mux_pkg::output_latch_a_off: begin
        rd_byte[7:4] = latch_reg & {usable, 2'b11};
      end
      pin_mux_pkg::direction_a_off: begin
        rd_byte[7:4] = dir_reg & {usable, 2'b11};
      end
      pin_mux_pkg::analog_select_a_off: begin
        rd_byte[pin_mux_pkg::ans_bit5_pos] = ans5_reg;
      end
      pin_mux_pkg::slew_rate_control_off: begin
        rd_byte[pin_mux_pkg::slew_width-1:0] = slew_reg;
      end
      pin_mux_pkg::osc_config_off: begin
        rd_byte[pin_mux_pkg::osc_mode_pos +: 2] = osc_mode_reg;
        rd_byte[pin_mux_pkg::clkout_en_pos] = clkout_en_reg;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= pin_mux_pkg::resp_okay;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= mapped(araddr) ? pin_mux_pkg::resp_okay
                              : pin_mux_pkg::resp_slverr;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Pin output arbitration
  logic [7:4] out_next;
  logic [7:4] oe_n_next;
  always_comb begin
    // Pin 4: fixed priority chain
    if (periph_req.sr_q_en) begin
      out_next[4] = periph_req.sr_latch_true_out;
    end else if (periph_req.c1_en) begin
      out_next[4] = periph_req.comparator1_output;
    end else if (periph_req.cmp_pwm5_en) begin
      out_next[4] = periph_req.compare_pwm_unit5_out;
    end else begin
      out_next[4] = latch_reg[4];
    end
    oe_n_next[4] = dir_reg[4];
    // Pin 5: analog select never blocks the driver
    if (periph_req.sr_nq_en) begin
      out_next[5] = periph_req.sr_latch_inverted_out;
    end else if (periph_req.c2_en) begin
      out_next[5] = periph_req.comparator2_output;
    end else begin
      out_next[5] = latch_reg[5];
    end
    oe_n_next[5] = dir_reg[5];
    // Pin 6: clock output ignores direction
    if (clk_drive) begin
      out_next[6] = clk_div_reg[1];
      oe_n_next[6] = 1'b0;
    end else if (usable[6]) begin
      out_next[6] = latch_reg[6];
      oe_n_next[6] = dir_reg[6];
    end else begin
      out_next[6] = 1'b0;
      oe_n_next[6] = 1'b1;
    end
    // Pin 7: driver off whenever the oscillator owns it
    out_next[7] = latch_reg[7] && usable[7];
    oe_n_next[7] = !usable[7] || dir_reg[7];
  end

  // Free-running divide by four of the oscillator-derived clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_div_reg <= 2'h0;
    end else begin
      clk_div_reg <= clk_div_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 4'h0;
      pin_oe_n <= 4'hf;
    end else begin
      pin_out <= out_next;
      pin_oe_n <= oe_n_next;
    end
  end

  // ==========================================================
  // Input routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer0_ext_clock_in <= 1'b0;
      spi_client_select_in <= 1'b1;
      external_clock_in <= 1'b0;
    end else begin
      timer0_ext_clock_in <= dir_reg[4] && pin_in[4];
      // Select is active low, so a blocked path reads as deselected
      spi_client_select_in <= (dir_reg[5] && !ans5_reg) ? pin_in[5]
                                                        : 1'b1;
      external_clock_in <= pin_in[7];
    end
  end

  // ==========================================================
  // Assertions
  sequence s_sr_true_forced;
    periph_req.sr_q_en && !dir_reg[4];
  endsequence

  a_reset_pin4_input: assert property (@(posedge aclk)
    !aresetn |=> pin_oe_n[4] && dir_reg[4])
    else $error("pin 4 not an input after reset");

  a_pwm5_drives_pin4: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!dir_reg[4] && periph_req.cmp_pwm5_en && !periph_req.sr_q_en &&
     !periph_req.c1_en) |=>
    !pin_oe_n[4] && pin_out[4] == $past(periph_req.compare_pwm_unit5_out))
    else $error("compare output lost on pin 4");

  a_sr_true_wins: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_sr_true_forced |=>
    !pin_oe_n[4] && pin_out[4] == $past(periph_req.sr_latch_true_out))
    else $error("sr latch output lost on pin 4");

  a_c1_over_pwm5: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (periph_req.c1_en && !periph_req.sr_q_en) |=>
    pin_out[4] == $past(periph_req.comparator1_output))
    else $error("comparator 1 priority wrong on pin 4");

  a_timer_clock_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    dir_reg[4] |=> timer0_ext_clock_in == $past(pin_in[4]))
    else $error("timer clock not routed from pin 4");

  a_pin5_analog_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr == pin_mux_pkg::port_pins_a_off &&
     ans5_reg) |=> !rdata[5])
    else $error("analog pin 5 read not zero");

  a_spi_select_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (dir_reg[5] && !ans5_reg) |=>
    spi_client_select_in == $past(pin_in[5]))
    else $error("client select not routed from pin 5");

  // Three cycles, so the two-cycle look-back already saw the clock
  a_clock_out_pin6: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clkout_en_reg && osc_mode_reg == pin_mux_pkg::osc_rc) [*3] |=>
    !pin_oe_n[6] && pin_out[6] != $past(pin_out[6], 2))
    else $error("quarter clock missing on pin 6");

  a_pin7_ext_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (osc_mode_reg != pin_mux_pkg::osc_internal) |=> pin_oe_n[7])
    else $error("pin 7 driven in external mode");

  a_ext_clock_tie: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> external_clock_in == $past(pin_in[7]))
    else $error("external clock not tied to pin 7");

endmodule : port_a_upper_pin_mux

/* File: bench/pin_world_model.sv */
// Far side of the pin multiplexer: pad levels seen by the block
`timescale 1ns/1ps

module pin_world_model (
  // Design drive side
  input wire logic [7:4] pin_out,
  input wire logic [7:4] pin_oe_n,
  // Level forced by the outside circuit
  input wire logic [7:4] ext_level,
  // Resolved pad levels
  output logic [7:4] pin_in
);
  // ==========================================================
  // Pad resolution
  // A driven pad shows the block's value; else the outside level wins
  always_comb begin
    for (int i = 4; i < 8; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule : pin_world_model

/* File: bench/test_port_a_upper_pin_mux.sv */
// Self-checking bench for the upper port pin multiplexer
`timescale 1ns/1ps

module test_port_a_upper_pin_mux;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pin_mux_pkg::periph_req_s pr = '0;
  logic [7:4] ext_level = 4'h0;
  logic [7:4] pin_in, pin_out, pin_oe_n;
  logic t0, ss, eclk;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  port_a_upper_pin_mux u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .periph_req(pr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .timer0_ext_clock_in(t0),
    .spi_client_select_in(ss), .external_clock_in(eclk)
  );

  pin_world_model u_world (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in)
  );

  initial begin
    forever #2 aclk = ~aclk;
  end

  // ==========================================================
  // Common tasks
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic wrx(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : wrx

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
  endtask : rdc

  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask : settle

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check(32'(pin_oe_n), 32'hf);
    rdc(pin_mux_pkg::direction_a_off, 32'hf0);
    rdc(pin_mux_pkg::analog_select_a_off, 32'h20);
    rdc(pin_mux_pkg::slew_rate_control_off, 32'h1f);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pin4_out();
    wrx(pin_mux_pkg::direction_a_off, 8'he0);
    wrx(pin_mux_pkg::output_latch_a_off, 8'h10);
    settle();
    check(32'({pin_oe_n[4], pin_out[4]}), 32'h1);
    pr.cmp_pwm5_en <= 1'b1;
    settle();
    check(32'(pin_out[4]), 32'h0);
    pr.c1_en <= 1'b1;
    pr.comparator1_output <= 1'b1;
    settle();
    check(32'(pin_out[4]), 32'h1);
    pr.sr_q_en <= 1'b1;
    settle();
    check(32'(pin_out[4]), 32'h0);
    pr <= '0;
    $display("test pin4 output done");
  endtask : t_pin4_out

  task automatic t_pin4_in();
    wrx(pin_mux_pkg::direction_a_off, 8'hf0);
    ext_level[4] <= 1'b1;
    settle();
    check(32'({pin_oe_n[4], t0}), 32'h3);
    ext_level[4] <= 1'b0;
    settle();
    check(32'(t0), 32'h0);
    $display("test pin4 input done");
  endtask : t_pin4_in

  task automatic t_pin5();
    wrx(pin_mux_pkg::direction_a_off, 8'hd0);
    wrx(pin_mux_pkg::output_latch_a_off, 8'h20);
    settle();
    check(32'({pin_oe_n[5], pin_out[5]}), 32'h1);
    pr.c2_en <= 1'b1;
    settle();
    check(32'(pin_out[5]), 32'h0);
    pr.sr_nq_en <= 1'b1;
    pr.sr_latch_inverted_out <= 1'b1;
    settle();
    check(32'(pin_out[5]), 32'h1);
    pr <= '0;
    wrx(pin_mux_pkg::direction_a_off, 8'hf0);
    ext_level[5] <= 1'b1;
    rdc(pin_mux_pkg::port_pins_a_off, 32'h0);
    ext_level[5] <= 1'b0;
    settle();
    check(32'(ss), 32'h1);
    wrx(pin_mux_pkg::analog_select_a_off, 8'h00);
    settle();
    check(32'(ss), 32'h0);
    ext_level[5] <= 1'b1;
    rdc(pin_mux_pkg::port_pins_a_off, 32'h20);
    $display("test pin5 done");
  endtask : t_pin5

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    ext_level <= 4'h0;
    wrx(pin_mux_pkg::port_pins_a_off, 8'h5a);
    rdc(pin_mux_pkg::output_latch_a_off, 32'h50);
    wrx(pin_mux_pkg::slew_rate_control_off, 8'hff);
    rdc(pin_mux_pkg::slew_rate_control_off, 32'h1f);
    rd(8'h40, d, r);
    check(d, 32'h0);
    check(32'(r), 32'h2);
    wr(8'h40, 8'hff, r);
    check(32'(r), 32'h2);
    $display("test bus done");
  endtask : t_bus

  task automatic t_osc();
    int n;
    logic prev;
    wrx(pin_mux_pkg::output_latch_a_off, 8'hc0);
    wrx(pin_mux_pkg::direction_a_off, 8'h30);
    settle();
    check(32'({pin_oe_n[7:6], pin_out[7:6]}), 32'h3);
    rdc(pin_mux_pkg::port_pins_a_off, 32'hc0);
    wrx(pin_mux_pkg::direction_a_off, 8'hf0);
    wrx(pin_mux_pkg::osc_config_off, 8'h05);
    settle();
    check(32'(pin_oe_n[6]), 32'h0);
    n = 0;
    prev = pin_out[6];
    repeat (8) begin
      @(posedge aclk);
      if (pin_out[6] !== prev) n++;
      prev = pin_out[6];
    end
    check(32'(n), 32'h4);
    rdc(pin_mux_pkg::direction_a_off, 32'h30);
    for (int m = 2; m < 4; m++) begin
      wrx(pin_mux_pkg::osc_config_off, 8'(m));
      wrx(pin_mux_pkg::direction_a_off, 8'h30);
      settle();
      check(32'(pin_oe_n[7]), 32'h1);
    end
    ext_level[7] <= 1'b1;
    settle();
    check(32'(eclk), 32'h1);
    rdc(pin_mux_pkg::port_pins_a_off, 32'h0);
    rdc(pin_mux_pkg::output_latch_a_off, 32'h0);
    ext_level[7] <= 1'b0;
    settle();
    check(32'(eclk), 32'h0);
    wrx(pin_mux_pkg::osc_config_off, 8'h04);
    settle();
    check(32'(pin_oe_n[6]), 32'h0);
    rdc(pin_mux_pkg::output_latch_a_off, 32'h80);
    $display("test oscillator done");
  endtask : t_osc

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_pin4_out();
    t_pin4_in();
    t_pin5();
    t_bus();
    t_osc();
    tally_and_finish();
  end
endmodule : test_port_a_upper_pin_mux
